// ===== core/tat_core.sv
// reference tracking, limit calculation, debounce, scan triggers and clock dividers
// ==========================================================
// Summary of operation
// - software loads one channel's reference level after calibration
// - with tracking on, reference steps toward each new sample
// - each step is reference times tracking ratio
// - tracking acts only in low-power mode
// - limit tracking on makes hardware compute and store both limits
// - limits are reference plus and minus reference shifted by ratio plus one
// - debounce count sets out-of-range events needed per interrupt
// - end-of-scan interrupt is raised on every scan, never debounced
// - scans start by software bit, hardware trigger or periodic trigger
// - periodic enable starts periodic scans and ignores other triggers
// - period comes from trigger clock, its divider and interval count
// - trigger clock is low-power oscillator or divided function clock
// - function clock is fast oscillator or external clock, then divided
// - finger strength offers eight equal steps of 148 pF up to 1184 pF
// - finger enable makes the electrode appear touched
`timescale 1ns/1ps
`include "tat_map.svh"
module tat_core
  import tat_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        fast_osc_in,
  input  wire logic        ext_clk_in,
  input  wire logic        low_power_osc_in,
  input  wire logic        hw_trigger_in,
  input  wire logic        scan_done,
  input  wire logic [15:0] scan_value,
  output logic             scan_start,
  output logic             func_clk_en,
  output logic             finger_enable,
  output logic [10:0]      finger_cap_pf,
  output logic             irq
);
  // ==========================================================
  // declarations
  logic [31:0] ctrl_q, per_q, lim_q;
  logic [7:0]  clk_q;
  logic [3:0]  fng_q;
  logic [1:0]  stat_q, mask_q, stat_set;
  tat_level_t  ref_q, sample_q, upper, lower, calc_hi, calc_lo, shift_amt, step;
  logic [16:0] sum_hi;
  logic [23:0] prod;
  logic [7:0]  dph_addr_q, fdiv_cnt_q, tdiv_cnt_q;
  logic        dph_wr_q, acc_ph, wr_en;
  logic [3:0]  pin_lvl, pin_prev_q, pin_rise;
  logic [3:0]  deb_cnt_q, deb_need;
  logic [15:0] ivl_cnt_q, ivl_need;
  logic        fsrc_edge, tsrc_edge, trig_tick, auto_pulse, sw_pulse, hw_pulse;
  logic        out_range, ref_wr, trk_act;
  tat_fsrc_t   fsrc;
  tat_tsrc_t   tsrc;

  // ==========================================================
  // pin synchronisers for oscillators, external clock and hardware trigger
  logic [3:0] pins;
  assign pins = {hw_trigger_in, low_power_osc_in, ext_clk_in, fast_osc_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      tat_sync3 u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin_in  (pins[gi]),
        .level_q (pin_lvl[gi])
      );
      assign pin_rise[gi] = pin_lvl[gi] & ~pin_prev_q[gi];
    end
  endgenerate

  // edge detect registers on synchronised levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) pin_prev_q <= 4'h0;
    else pin_prev_q <= pin_lvl;
  end

  // ==========================================================
  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc_ph    = hsel & htrans[1] & hready;
  assign wr_en     = dph_wr_q;

  // latch the address phase of a write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      dph_wr_q   <= acc_ph & hwrite;
      dph_addr_q <= haddr[7:0];
    end
  end

  // read data registered from the address phase; unmapped reads zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_ph && !hwrite) begin
      case (haddr[7:0])
        `TAT_OFF_CTRL:     hrdata <= ctrl_q & ~(32'h1 << `TAT_CTRL_SWTRIG);
        `TAT_OFF_REF:      hrdata <= {16'h0000, ref_q};
        `TAT_OFF_LIMIT:    hrdata <= lim_q;
        `TAT_OFF_SAMPLE:   hrdata <= {16'h0000, sample_q};
        `TAT_OFF_PERIODIC: hrdata <= per_q;
        `TAT_OFF_CLKCFG:   hrdata <= {24'h000000, clk_q};
        `TAT_OFF_FINGER:   hrdata <= {28'h0000000, fng_q};
        `TAT_OFF_STATUS:   hrdata <= {30'h0, stat_q};
        `TAT_OFF_MASK:     hrdata <= {30'h0, mask_q};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // plain configuration registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 32'h0000_0000;
      per_q  <= 32'h0000_0000;
      clk_q  <= 8'h00;
      fng_q  <= 4'h0;
      mask_q <= 2'h0;
    end else if (wr_en) begin
      case (dph_addr_q)
        `TAT_OFF_CTRL:     ctrl_q <= {13'h0, hwdata[18:0]};
        `TAT_OFF_PERIODIC: per_q  <= hwdata & 32'hFFFF_FF03;
        `TAT_OFF_CLKCFG:   clk_q  <= hwdata[7:0] & 8'hF1;
        `TAT_OFF_FINGER:   fng_q  <= hwdata[3:0];
        `TAT_OFF_MASK:     mask_q <= hwdata[1:0];
        default:           ;
      endcase
    end
  end

  // software trigger is a one-cycle pulse from a write of one
  assign sw_pulse = wr_en && (dph_addr_q == `TAT_OFF_CTRL) && hwdata[`TAT_CTRL_SWTRIG];
  assign hw_pulse = pin_rise[3];

  // ==========================================================
  // function clock: source select then divide by field plus one
  assign fsrc = tat_fsrc_t'(clk_q[`TAT_CLK_SEL]);
  always_comb begin
    case (fsrc)
      TAT_FUNC_FAST: fsrc_edge = pin_rise[0];
      TAT_FUNC_EXT:  fsrc_edge = pin_rise[1];
      default:       fsrc_edge = 1'b0;
    endcase
  end

  // divider counter for the function clock enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fdiv_cnt_q  <= 8'h00;
      func_clk_en <= 1'b0;
    end else begin
      func_clk_en <= 1'b0;
      if (fsrc_edge) begin
        if (fdiv_cnt_q >= {4'h0, clk_q[`TAT_CLK_DIV_HI:`TAT_CLK_DIV_LO]}) begin
          fdiv_cnt_q  <= 8'h00;
          func_clk_en <= 1'b1;
        end else begin
          fdiv_cnt_q <= fdiv_cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // trigger clock: low-power oscillator or divided function clock
  assign tsrc = tat_tsrc_t'(per_q[`TAT_PER_SEL]);
  always_comb begin
    case (tsrc)
      TAT_TRIG_FUNC:  tsrc_edge = func_clk_en;
      TAT_TRIG_LPOSC: tsrc_edge = pin_rise[2];
      default:        tsrc_edge = 1'b0;
    endcase
  end

  // trigger divider and interval counter, zero interval treated as one
  assign ivl_need = (per_q[`TAT_PER_CNT_HI:`TAT_PER_CNT_LO] == 16'h0000) ? 16'h0001 :
                    per_q[`TAT_PER_CNT_HI:`TAT_PER_CNT_LO];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tdiv_cnt_q <= 8'h00;
      trig_tick  <= 1'b0;
      ivl_cnt_q  <= 16'h0000;
      auto_pulse <= 1'b0;
    end else if (!per_q[`TAT_PER_EN]) begin
      tdiv_cnt_q <= 8'h00;
      trig_tick  <= 1'b0;
      ivl_cnt_q  <= 16'h0000;
      auto_pulse <= 1'b0;
    end else begin
      trig_tick  <= 1'b0;
      auto_pulse <= 1'b0;
      if (tsrc_edge) begin
        if (tdiv_cnt_q >= per_q[`TAT_PER_DIV_HI:`TAT_PER_DIV_LO]) begin
          tdiv_cnt_q <= 8'h00;
          trig_tick  <= 1'b1;
        end else begin
          tdiv_cnt_q <= tdiv_cnt_q + 8'h01;
        end
      end
      if (trig_tick) begin
        if (ivl_cnt_q + 16'h0001 >= ivl_need) begin
          ivl_cnt_q  <= 16'h0000;
          auto_pulse <= 1'b1;
        end else begin
          ivl_cnt_q <= ivl_cnt_q + 16'h0001;
        end
      end
    end
  end

  // scan start: periodic trigger overrides software and hardware sources
  assign scan_start = per_q[`TAT_PER_EN] ? auto_pulse : (sw_pulse | hw_pulse);

  // ==========================================================
  // reference tracking step: reference times ratio in 1/256 units, at least one
  assign prod   = ref_q * ctrl_q[`TAT_CTRL_TRR_HI:`TAT_CTRL_TRR_LO];
  assign step   = (prod[23:8] == 16'h0000) ? 16'h0001 : prod[23:8];
  assign ref_wr = wr_en && (dph_addr_q == `TAT_OFF_REF);
  assign trk_act = ctrl_q[`TAT_CTRL_TRK_EN] & ctrl_q[`TAT_CTRL_LOWPWR] & scan_done;

  // reference register: software load wins, else converge without overshoot
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= `TAT_RST_REF;
    end else if (ref_wr) begin
      ref_q <= hwdata[15:0];
    end else if (trk_act) begin
      if (scan_value > ref_q) begin
        ref_q <= (scan_value - ref_q > step) ? ref_q + step : scan_value;
      end else if (scan_value < ref_q) begin
        ref_q <= (ref_q - scan_value > step) ? ref_q - step : scan_value;
      end
    end
  end

  // last sample for software
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) sample_q <= 16'h0000;
    else if (scan_done) sample_q <= scan_value;
  end

  // ==========================================================
  // limit calculation from the reference, upper limit saturates
  assign shift_amt = ref_q >> ({1'b0, ctrl_q[`TAT_CTRL_LMR_HI:`TAT_CTRL_LMR_LO]} + 4'h1);
  assign sum_hi    = {1'b0, ref_q} + {1'b0, shift_amt};
  assign calc_hi   = sum_hi[16] ? 16'hFFFF : sum_hi[15:0];
  assign calc_lo   = ref_q - shift_amt;

  // limit register: hardware reload while limit tracking is on, else software writable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lim_q <= `TAT_RST_LIMIT;
    end else if (ctrl_q[`TAT_CTRL_LIM_EN]) begin
      lim_q <= {calc_hi, calc_lo};
    end else if (wr_en && (dph_addr_q == `TAT_OFF_LIMIT)) begin
      lim_q <= hwdata;
    end
  end
  assign upper = lim_q[31:16];
  assign lower = lim_q[15:0];

  // ==========================================================
  // debounce of out-of-range events, zero count treated as one
  assign out_range = (scan_value > upper) || (scan_value < lower);
  assign deb_need  = (ctrl_q[`TAT_CTRL_DEB_HI:`TAT_CTRL_DEB_LO] == 4'h0) ? 4'h1 :
                     ctrl_q[`TAT_CTRL_DEB_HI:`TAT_CTRL_DEB_LO];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      deb_cnt_q <= 4'h0;
    end else if (scan_done) begin
      if (!out_range) deb_cnt_q <= 4'h0;
      else if (deb_cnt_q + 4'h1 >= deb_need) deb_cnt_q <= 4'h0;
      else deb_cnt_q <= deb_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // sticky status, set wins over write-one-to-clear
  assign stat_set[`TAT_ST_EOS] = scan_done;
  assign stat_set[`TAT_ST_OOR] = scan_done && out_range && (deb_cnt_q + 4'h1 >= deb_need);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= 2'h0;
    end else if (wr_en && (dph_addr_q == `TAT_OFF_STATUS)) begin
      stat_q <= (stat_q & ~hwdata[1:0]) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) irq <= 1'b0;
    else irq <= |(stat_q & mask_q);
  end

  // ==========================================================
  // emulated finger: capacitance code is strength plus one times the step
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      finger_enable <= 1'b0;
      finger_cap_pf <= 11'h000;
    end else begin
      finger_enable <= fng_q[`TAT_FNG_EN];
      finger_cap_pf <= fng_q[`TAT_FNG_EN] ?
        11'((fng_q[`TAT_FNG_STR_HI:`TAT_FNG_STR_LO] + 4'h1) * `TAT_FINGER_STEP) : 11'h000;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_oor_hit;
    scan_done && out_range && (deb_cnt_q + 4'h1 >= deb_need) && !ref_wr;
  endsequence
  sequence s_track_up;
    trk_act && !ref_wr && (scan_value > ref_q);
  endsequence
  sequence s_limits_loaded;
    upper == $past(calc_hi) && lower == $past(calc_lo);
  endsequence
  sequence s_oor_after;
    stat_q[1] && deb_cnt_q == 4'h0 ##1 (irq || !$past(mask_q[1]));
  endsequence

  AST_AUTO_OVERRIDE: assert property (per_q[0] && !auto_pulse |-> !scan_start)
    else $error("trigger passed while periodic mode active");
  AST_SW_START: assert property (!per_q[0] && sw_pulse |-> scan_start)
    else $error("software trigger lost");
  AST_NO_TRACK_RUN: assert property (!ctrl_q[2] && !ref_wr |=> $stable(ref_q))
    else $error("reference moved outside low-power mode");
  AST_TRACK_UP: assert property (s_track_up |=> ref_q > $past(ref_q))
    else $error("reference did not rise toward sample");
  AST_LIMIT_CALC: assert property (ctrl_q[1] |=> s_limits_loaded)
    else $error("limits not reloaded");
  AST_EOS_SET: assert property (scan_done |=> stat_q[0])
    else $error("end-of-scan status missing");
  AST_OOR_SET: assert property (s_oor_hit |=> s_oor_after)
    else $error("out-of-range interrupt wrong");
  AST_DEB_CLEAR: assert property (scan_done && !out_range |=> deb_cnt_q == 4'h0)
    else $error("debounce count not cleared");
  AST_FINGER: assert property (fng_q[3] ##1 fng_q[3] |-> finger_enable && |finger_cap_pf)
    else $error("finger not applied");
endmodule

// ===== core/tat_sync3.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module tat_sync3 (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q, s2_q, s3_q;

  // ==========================================================
  // shift chain
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // accept the level only once two later stages match
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// ===== include/tat_map.svh
// register offsets, field positions, reset values and fixed counts of the autotune block
`ifndef TAT_MAP_SVH
`define TAT_MAP_SVH
// ==========================================================
// register byte offsets
`define TAT_OFF_CTRL     8'h00
`define TAT_OFF_REF      8'h04
`define TAT_OFF_LIMIT    8'h08
`define TAT_OFF_SAMPLE   8'h0C
`define TAT_OFF_PERIODIC 8'h10
`define TAT_OFF_CLKCFG   8'h14
`define TAT_OFF_FINGER   8'h18
`define TAT_OFF_STATUS   8'h1C
`define TAT_OFF_MASK     8'h20
// ==========================================================
// control register fields
`define TAT_CTRL_TRK_EN  0
`define TAT_CTRL_LIM_EN  1
`define TAT_CTRL_LOWPWR  2
`define TAT_CTRL_SWTRIG  3
`define TAT_CTRL_DEB_LO  4
`define TAT_CTRL_DEB_HI  7
`define TAT_CTRL_TRR_LO  8
`define TAT_CTRL_TRR_HI  15
`define TAT_CTRL_LMR_LO  16
`define TAT_CTRL_LMR_HI  18
// ==========================================================
// periodic, clock and finger fields
`define TAT_PER_EN       0
`define TAT_PER_SEL      1
`define TAT_PER_DIV_LO   8
`define TAT_PER_DIV_HI   15
`define TAT_PER_CNT_LO   16
`define TAT_PER_CNT_HI   31
`define TAT_CLK_SEL      0
`define TAT_CLK_DIV_LO   4
`define TAT_CLK_DIV_HI   7
`define TAT_FNG_STR_LO   0
`define TAT_FNG_STR_HI   2
`define TAT_FNG_EN       3
// ==========================================================
// status bits, reset values and fixed figures
`define TAT_ST_EOS       0
`define TAT_ST_OOR       1
`define TAT_RST_LIMIT    32'hFFFF_0000
`define TAT_RST_REF      16'h0000
`define TAT_FINGER_STEP  11'h094
`define TAT_TRK_FRAC     8
`endif

// ===== include/tat_pkg.sv
// types shared by the autotune trigger block
package tat_pkg;
  // ==========================================================
  // level and source types
  typedef logic [15:0] tat_level_t;
  typedef enum logic {TAT_FUNC_FAST, TAT_FUNC_EXT} tat_fsrc_t;
  typedef enum logic {TAT_TRIG_FUNC, TAT_TRIG_LPOSC} tat_tsrc_t;
endpackage

// ===== verification/tb_top.sv
// self-checking testbench for the autotune trigger block
`timescale 1ns/1ps
`include "tat_map.svh"
module tb_top
  import tat_pkg::*;
;
  // ==========================================================
  // design connections
  logic        ref_clk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        fast_osc_in;
  logic        ext_clk_in;
  logic        low_power_osc_in;
  logic        hw_trigger_in;
  logic        scan_done;
  logic [15:0] scan_value;
  logic        scan_start;
  logic        func_clk_en;
  logic        finger_enable;
  logic [10:0] finger_cap_pf;
  logic        irq;
  int          fail_count;
  int          total_checks;
  int          cyc;
  int          n_start;
  int          last_s;
  int          gap_s;
  int          last_f;
  int          gap_f;
  logic [31:0] rd;

  tat_core tat_core_i (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_osc_in(fast_osc_in),
    .ext_clk_in(ext_clk_in), .low_power_osc_in(low_power_osc_in),
    .hw_trigger_in(hw_trigger_in), .scan_done(scan_done), .scan_value(scan_value),
    .scan_start(scan_start), .func_clk_en(func_clk_en), .finger_enable(finger_enable),
    .finger_cap_pf(finger_cap_pf), .irq(irq));

  // ==========================================================
  // clock, free-running oscillator pins, pulse monitor
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    fast_osc_in      <= (cyc % 6) < 3;
    ext_clk_in       <= (cyc % 8) < 4;
    low_power_osc_in <= (cyc % 20) < 10;
  end
  // counts start pulses and the spacing of both pulse outputs
  always @(negedge ref_clk) begin
    cyc++;
    if (scan_start === 1'b1) begin
      n_start++;
      gap_s = cyc - last_s;
      last_s = cyc;
    end
    if (func_clk_en === 1'b1) begin
      gap_f = cyc - last_f;
      last_f = cyc;
    end
    if (cyc > 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one single transfer: address phase, then data phase, each held until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] data);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    data = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    ahb(1'b0, a, 32'h00000000, v);
    check(v, exp, msg);
  endtask
  // control word: tracking, limits, low power, debounce, tracking ratio, limit ratio
  function automatic logic [31:0] ctl(input logic t, input logic l, input logic p,
                                      input logic [3:0] db, input logic [7:0] tr,
                                      input logic [2:0] lr);
    return {13'h0, lr, tr, db, 1'b0, p, l, t};
  endfunction
  task automatic scan(input logic [15:0] v);
    @(posedge ref_clk);
    scan_done  <= 1'b1;
    scan_value <= v;
    @(posedge ref_clk);
    scan_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_and_tracking();
    check(hreadyout, 1'b1, "no wait states");
    check(hresp, 1'b0, "response okay");
    rdc(`TAT_OFF_LIMIT, 32'hFFFF0000, "limit reset");
    rdc(`TAT_OFF_REF, 32'h00000000, "ref reset");
    rdc(8'h40, 32'h00000000, "unmapped read");
    wr(`TAT_OFF_REF, 32'h000003E8);
    wr(`TAT_OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h1, 8'h80, 3'h0));
    scan(16'h07D0);
    rdc(`TAT_OFF_REF, 32'h000003E8, "no tracking in run mode");
    wr(`TAT_OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, 4'h1, 8'h80, 3'h0));
    scan(16'h07D0);
    rdc(`TAT_OFF_REF, 32'h000005DC, "step up by ref*ratio");
    rdc(`TAT_OFF_LIMIT, 32'h08CA02EE, "limits follow ref");
    wr(`TAT_OFF_LIMIT, 32'h12345678);
    rdc(`TAT_OFF_LIMIT, 32'h08CA02EE, "limit write ignored");
    scan(16'h07D0);
    rdc(`TAT_OFF_REF, 32'h000007D0, "step stops at sample");
    scan(16'h03E8);
    rdc(`TAT_OFF_REF, 32'h000003E8, "step down");
    rdc(`TAT_OFF_SAMPLE, 32'h000003E8, "last sample");
  endtask

  task automatic t_debounce();
    wr(`TAT_OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h2, 8'h00, 3'h1));
    wr(`TAT_OFF_REF, 32'h000003E8);
    wr(`TAT_OFF_MASK, 32'h00000002);
    wr(`TAT_OFF_STATUS, 32'h00000003);
    rdc(`TAT_OFF_LIMIT, 32'h04E202EE, "limits ratio one");
    scan(16'h07D0);
    scan(16'h03E8);
    scan(16'h07D0);
    rdc(`TAT_OFF_STATUS, 32'h00000001, "in-range clears count");
    check(irq, 1'b0, "irq before debounce");
    scan(16'h0064);
    rdc(`TAT_OFF_STATUS, 32'h00000003, "raised after two events");
    check(irq, 1'b1, "irq on out of range");
    wr(`TAT_OFF_STATUS, 32'h00000003);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0, "irq cleared");
    scan(16'h07D0);
    rdc(`TAT_OFF_STATUS, 32'h00000001, "count cleared by irq");
    check(irq, 1'b0, "end of scan masked");
    scan(16'h07D0);
    check(irq, 1'b1, "second raise");
    wr(`TAT_OFF_MASK, 32'h00000000);
    wr(`TAT_OFF_STATUS, 32'h00000003);
  endtask

  task automatic t_triggers();
    int s0;
    s0 = n_start;
    wr(`TAT_OFF_CTRL, 32'h00000008);
    repeat (2) @(posedge ref_clk);
    check(n_start - s0, 1, "software trigger");
    hw_trigger_in <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(n_start - s0, 2, "hardware trigger");
    hw_trigger_in <= 1'b0;
    wr(`TAT_OFF_CLKCFG, 32'h00000000);
    repeat (40) @(posedge ref_clk);
    check(gap_f, 6, "fast source undivided");
    wr(`TAT_OFF_CLKCFG, 32'h00000011);
    repeat (60) @(posedge ref_clk);
    check(gap_f, 16, "external source by two");
    wr(`TAT_OFF_PERIODIC, 32'h00020101);
    repeat (300) @(posedge ref_clk);
    check(gap_s, 64, "period on function clock");
    wr(`TAT_OFF_PERIODIC, 32'hFFFF0001);
    repeat (80) @(posedge ref_clk);
    s0 = n_start;
    wr(`TAT_OFF_CTRL, 32'h00000008);
    hw_trigger_in <= 1'b1;
    repeat (12) @(posedge ref_clk);
    check(n_start - s0, 0, "other triggers ignored");
    hw_trigger_in <= 1'b0;
    wr(`TAT_OFF_PERIODIC, 32'h00030003);
    repeat (250) @(posedge ref_clk);
    check(gap_s, 60, "period on low-power osc");
    wr(`TAT_OFF_PERIODIC, 32'h00000000);
  endtask

  task automatic t_finger();
    for (int s = 0; s < 8; s++) begin
      wr(`TAT_OFF_FINGER, s);
      wr(`TAT_OFF_FINGER, s | 8);
      repeat (2) @(posedge ref_clk);
      check(finger_enable, 1'b1, "finger on");
      check(finger_cap_pf, (s + 1) * 148, "finger strength");
    end
    wr(`TAT_OFF_FINGER, 32'h00000000);
    repeat (2) @(posedge ref_clk);
    check(finger_cap_pf, 11'h000, "finger off");
    check(finger_enable, 1'b0, "finger released");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hw_trigger_in, scan_done, scan_value} = '0;
    hsize = 3'h2;
    {fast_osc_in, ext_clk_in, low_power_osc_in} = 3'h0;
    {fail_count, total_checks, cyc, n_start, last_s, gap_s, last_f, gap_f} = '0;
    nrst = 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset_and_tracking();
    t_debounce();
    t_triggers();
    t_finger();
    give_verdict();
  end
endmodule
